// ===== design/flash_command_sequencer.sv
`timescale 1ns/1ns
// Summary of operation
// - Primary array has 8 equal sectors, secondary array has 4.
// - Protected sectors ignore program and erase.
// - Erase works per whole sector; program writes one 16-bit word.
// - Sector erase can pause, allow reads of other sectors, then resume.
// - Ready/busy pin low while any program or erase runs.
// - Ready/busy pin high when nothing runs.
// - One select per sector for both arrays, each up to three terms.
// - Plain writes never store; only decoded commands change content.
// - With no command pending, selected reads return array words.
// - AA/55/90 preamble then read at 02 returns primary identifier.
// - Same preamble then read at 04 returns 01 protected, 00 otherwise.
// - AA/55/A0 then data word at target address starts program.
// - Five-write preamble then 30 at sector erases; more 30s add sectors.
// - Five-write preamble then 10 at AAA erases the whole array.
// - B0 pauses erase, 30 resumes, F0 returns to read, any address.
// - AA/55/20 enters bypass mode for shortened programs.
// - In bypass, A0 then data word programs one word.
// - In bypass, 90 then 00 leaves bypass to read mode.
// - Target array is whichever array has a select high.
// - Outside bypass, invalid byte or long gap abandons sequence to read mode.
// - Command decode compares only the low twelve address bits.
module flash_command_sequencer
  import flash_seq_pkg::*;
#(
  parameter int          PROG_TIME  = PROG_CYCLES,
  parameter int          ERASE_TIME = ERASE_CYCLES,
  parameter int          GAP_TIME   = GAP_CYCLES,
  parameter logic [15:0] ID_CODE    = 16'h005A  // Arbitrary identifier value
) (
  input  wire logic                   REF_CLK,
  input  wire logic                   RST_N,
  input  wire bus_req_t               BUS_REQ,
  input  wire logic [PRI_SECTORS-1:0] PRI_SEL,
  input  wire logic [SEC_SECTORS-1:0] SEC_SEL,
  input  wire logic [PRI_SECTORS-1:0] PRI_PROT,
  input  wire logic [SEC_SECTORS-1:0] SEC_PROT,
  output logic      [15:0]            RD_DATA,
  output logic                        READY_BUSY_PIN,
  output logic                        SUSPENDED
);
  localparam int NSECT = PRI_SECTORS + SEC_SECTORS;
  localparam int PRI_WORDS = PRI_SECTORS * (1 << PRI_SECT_W);
  localparam int SEC_WORDS = SEC_SECTORS * (1 << SEC_SECT_W);

  // Refuse timing values that the 16-bit gap timer or the busy counter cannot serve
  if (PROG_TIME < 1 || ERASE_TIME < 1 || GAP_TIME < 2 || GAP_TIME > 65535) begin
    $error("flash_command_sequencer: timing parameter out of range");
  end

  // Arrays: 8 equal primary sectors and 4 equal secondary sectors
  logic [15:0] pri_mem [PRI_WORDS];
  logic [15:0] sec_mem [SEC_WORDS];

  seq_state_t            state_reg, state_next;
  logic                  arr_reg, arr_next;          // 1 = secondary
  logic                  bypass_reg, bypass_next;
  logic                  is_erase_reg, is_erase_next;
  logic [NSECT-1:0]      emask_reg, emask_next;
  logic [15:0]           timer_reg, timer_next;
  logic [31:0]           busy_reg, busy_next;
  logic [ADDR_W-1:0]     paddr_reg, paddr_next;
  logic [15:0]           pdata_reg, pdata_next;
  logic                  do_prog, do_erase;
  logic [15:0]           rd_next;

  logic                  pri_hit, sec_hit, any_hit, req_arr;
  logic [CMD_ADDR_W-1:0] ca;
  logic [7:0]            cb;
  logic [NSECT-1:0]      sel_all, prot_all;

  // Decode helpers: which array is selected and which sector
  always_comb begin
    pri_hit  = |PRI_SEL;
    sec_hit  = |SEC_SEL;
    any_hit  = pri_hit | sec_hit;
    req_arr  = !pri_hit;
    ca       = BUS_REQ.addr[CMD_ADDR_W-1:0];
    cb       = BUS_REQ.data[7:0];
    sel_all  = {SEC_SEL, PRI_SEL};
    prot_all = {SEC_PROT, PRI_PROT};
  end

  function automatic logic is_cmd(input logic [11:0] a, input logic [7:0] d,
                                  input logic [11:0] ea, input logic [7:0] ed);
    is_cmd = (a == ea) && (d == ed);
  endfunction

  function automatic logic sector_protected(input logic arr, input logic [ADDR_W-1:0] a,
                                            input logic [NSECT-1:0] prot);
    if (arr)
      sector_protected = prot[PRI_SECTORS + int'(a[SEC_ADDR_W-1:SEC_SECT_W])];
    else
      sector_protected = prot[int'(a[PRI_ADDR_W-1:PRI_SECT_W])];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer next-state
  always_comb begin
    state_next    = state_reg;
    arr_next      = arr_reg;
    bypass_next   = bypass_reg;
    is_erase_next = is_erase_reg;
    emask_next    = emask_reg;
    paddr_next    = paddr_reg;
    pdata_next    = pdata_reg;
    busy_next     = busy_reg;
    do_prog       = 1'b0;
    do_erase      = 1'b0;
    timer_next    = (timer_reg != 16'h0000) ? timer_reg - 16'h0001 : 16'h0000;
    if (BUS_REQ.wr && any_hit && state_reg != ST_BUSY)
      timer_next = 16'(GAP_TIME);

    if (BUS_REQ.wr && any_hit && !(state_reg inside {ST_BUSY, ST_SUSP}) &&
        state_reg != ST_READ && state_reg != ST_BYP && req_arr != arr_reg) begin
      state_next = bypass_reg ? ST_BYP : ST_READ;
    end else begin
      unique case (state_reg)
        ST_READ: begin
          if (BUS_REQ.wr && any_hit) begin
            arr_next = req_arr;
            if (is_cmd(ca, cb, UNLOCK1_ADDR, CMD_UNLOCK1))
              state_next = ST_C1;
            // Other writes are dropped, never stored
          end
        end
        ST_C1: begin
          if (BUS_REQ.wr && any_hit)
            state_next = is_cmd(ca, cb, UNLOCK2_ADDR, CMD_UNLOCK2) ? ST_C2 : ST_READ;
          else if (timer_reg == 16'h0001)
            state_next = ST_READ;
        end
        ST_C2: begin
          if (BUS_REQ.wr && any_hit) begin
            state_next = ST_READ;
            if (is_cmd(ca, cb, UNLOCK1_ADDR, CMD_AUTOSEL))
              state_next = ST_AUTO;
            else if (is_cmd(ca, cb, UNLOCK1_ADDR, CMD_PROGRAM))
              state_next = ST_PDATA;
            else if (is_cmd(ca, cb, UNLOCK1_ADDR, CMD_ERASE))
              state_next = ST_E3;
            else if (is_cmd(ca, cb, UNLOCK1_ADDR, CMD_BYPASS)) begin
              state_next  = ST_BYP;
              bypass_next = 1'b1;
            end
          end else if (timer_reg == 16'h0001)
            state_next = ST_READ;
        end
        ST_AUTO: begin
          if (BUS_REQ.wr && any_hit && cb == CMD_RESET)
            state_next = ST_READ;
        end
        ST_PDATA, ST_BPDATA: begin
          if (BUS_REQ.wr && any_hit) begin
            paddr_next    = BUS_REQ.addr;
            pdata_next    = BUS_REQ.data;
            is_erase_next = 1'b0;
            busy_next     = 32'(PROG_TIME);
            state_next    = ST_BUSY;
          end else if (state_reg == ST_PDATA && timer_reg == 16'h0001)
            state_next = ST_READ;
        end
        ST_E3, ST_E4: begin
          if (BUS_REQ.wr && any_hit)
            state_next = (state_reg == ST_E3) ?
                         (is_cmd(ca, cb, UNLOCK1_ADDR, CMD_UNLOCK1) ? ST_E4 : ST_READ) :
                         (is_cmd(ca, cb, UNLOCK2_ADDR, CMD_UNLOCK2) ? ST_E5 : ST_READ);
          else if (timer_reg == 16'h0001)
            state_next = ST_READ;
        end
        ST_E5: begin
          if (BUS_REQ.wr && any_hit) begin
            state_next = ST_READ;
            if (cb == CMD_SECT_ER) begin
              emask_next = sel_all;
              state_next = ST_ECOLL;
            end else if (is_cmd(ca, cb, UNLOCK1_ADDR, CMD_CHIP_ER)) begin
              emask_next    = arr_reg ? {{SEC_SECTORS{1'b1}}, {PRI_SECTORS{1'b0}}}
                                      : {{SEC_SECTORS{1'b0}}, {PRI_SECTORS{1'b1}}};
              is_erase_next = 1'b1;
              busy_next     = 32'(ERASE_TIME);
              state_next    = ST_BUSY;
            end
          end else if (timer_reg == 16'h0001)
            state_next = ST_READ;
        end
        ST_ECOLL: begin
          // Collect extra sectors while 30 writes keep arriving within the window; any other write abandons to read
          if (BUS_REQ.wr && any_hit && cb == CMD_SECT_ER)
            emask_next = emask_reg | sel_all;
          else if (BUS_REQ.wr && any_hit)
            state_next = ST_READ;
          else if (timer_reg == 16'h0001) begin
            is_erase_next = 1'b1;
            busy_next     = 32'(ERASE_TIME);
            state_next    = ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (BUS_REQ.wr && any_hit && req_arr == arr_reg && cb == CMD_SUSPEND && is_erase_reg)
            state_next = ST_SUSP;
          else if (busy_reg <= 32'd1) begin
            do_prog     = !is_erase_reg;
            do_erase    = is_erase_reg;
            state_next  = bypass_reg ? ST_BYP : ST_READ;
          end else
            busy_next = busy_reg - 32'd1;
        end
        ST_SUSP: begin
          if (BUS_REQ.wr && any_hit && req_arr == arr_reg && cb == CMD_SECT_ER)
            state_next = ST_BUSY;
        end
        ST_BYP: begin
          if (BUS_REQ.wr && any_hit) begin
            arr_next = req_arr;
            if (cb == CMD_PROGRAM)
              state_next = ST_BPDATA;
            else if (cb == CMD_AUTOSEL)
              state_next = ST_BEXIT;
          end
        end
        ST_BEXIT: begin
          if (BUS_REQ.wr && any_hit) begin
            state_next = ST_BYP;
            if (cb == CMD_BYP_EXIT) begin
              bypass_next = 1'b0;
              state_next  = ST_READ;
            end
          end
        end
        default: state_next = ST_READ;
      endcase
    end
  end

  // Read data path: array word, identifier or protection status
  always_comb begin
    rd_next = RD_DATA;
    if (BUS_REQ.rd && any_hit) begin
      if (state_reg == ST_AUTO && req_arr == arr_reg && ca == ID_OFFS && !arr_reg)
        rd_next = ID_CODE;
      else if (state_reg == ST_AUTO && req_arr == arr_reg && ca == PROT_OFFS)
        rd_next = sector_protected(arr_reg, BUS_REQ.addr, prot_all) ? PROT_YES : PROT_NO;
      else if (req_arr)
        rd_next = sec_mem[BUS_REQ.addr[SEC_ADDR_W-1:0]];
      else
        rd_next = pri_mem[BUS_REQ.addr[PRI_ADDR_W-1:0]];
    end
  end

  // Array update only on algorithm completion, protection checked
  always_ff @(posedge REF_CLK) begin
    if (do_prog && !sector_protected(arr_reg, paddr_reg, prot_all)) begin
      if (arr_reg)
        sec_mem[paddr_reg[SEC_ADDR_W-1:0]] <= pdata_reg & sec_mem[paddr_reg[SEC_ADDR_W-1:0]];
      else
        pri_mem[paddr_reg[PRI_ADDR_W-1:0]] <= pdata_reg & pri_mem[paddr_reg[PRI_ADDR_W-1:0]];
    end
    if (do_erase) begin
      for (int s = 0; s < NSECT; s++) begin
        if (emask_reg[s] && !prot_all[s]) begin
          if (s < PRI_SECTORS)
            for (int w = 0; w < (1 << PRI_SECT_W); w++) pri_mem[s * (1 << PRI_SECT_W) + w] <= ERASED_WORD;
          else
            for (int w = 0; w < (1 << SEC_SECT_W); w++)
              sec_mem[(s - PRI_SECTORS) * (1 << SEC_SECT_W) + w] <= ERASED_WORD;
        end
      end
    end
  end

  // State registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg    <= ST_READ;
      arr_reg      <= 1'b0;
      bypass_reg   <= 1'b0;
      is_erase_reg <= 1'b0;
      emask_reg    <= '0;
      timer_reg    <= 16'h0000;
      busy_reg     <= 32'd0;
      paddr_reg    <= '0;
      pdata_reg    <= 16'h0000;
      RD_DATA      <= 16'h0000;
    end else begin
      state_reg    <= state_next;
      arr_reg      <= arr_next;
      bypass_reg   <= bypass_next;
      is_erase_reg <= is_erase_next;
      emask_reg    <= emask_next;
      timer_reg    <= timer_next;
      busy_reg     <= busy_next;
      paddr_reg    <= paddr_next;
      pdata_reg    <= pdata_next;
      RD_DATA      <= rd_next;
    end
  end

  // Busy low only while an algorithm is running
  assign READY_BUSY_PIN = (state_reg != ST_BUSY);
  assign SUSPENDED      = (state_reg == ST_SUSP);

  ////////////////////////////////////////////////////////////////////////////
  a_busy_low: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (state_reg == ST_BUSY) |-> !READY_BUSY_PIN)
    else $error("ready/busy high during algorithm");
  a_ready_high: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (state_reg inside {ST_READ, ST_SUSP}) |-> READY_BUSY_PIN)
    else $error("ready/busy low while idle");
  a_prog_start: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (state_reg == ST_PDATA && BUS_REQ.wr && any_hit && req_arr == arr_reg) |=> !READY_BUSY_PIN)
    else $error("program did not start");
  a_suspend_go: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (state_reg == ST_BUSY && is_erase_reg && BUS_REQ.wr && any_hit && req_arr == arr_reg
     && cb == CMD_SUSPEND) |=> SUSPENDED)
    else $error("suspend not taken");
  a_resume_go: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (SUSPENDED && BUS_REQ.wr && any_hit && req_arr == arr_reg && cb == CMD_SECT_ER)
    |=> !READY_BUSY_PIN)
    else $error("resume not taken");
  a_bad_byte: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (state_reg == ST_C1 && BUS_REQ.wr && any_hit && !arr_reg && !req_arr && cb != CMD_UNLOCK2)
    |=> state_reg == ST_READ)
    else $error("bad byte not abandoned");
  a_busy_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $fell(READY_BUSY_PIN) && !is_erase_reg |-> (PROG_TIME < 2) or (!READY_BUSY_PIN [*2]))
    else $error("busy released early");
  a_bypass_exit: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (state_reg == ST_BEXIT && BUS_REQ.wr && any_hit && req_arr == arr_reg && cb == CMD_BYP_EXIT)
    |=> (state_reg == ST_READ && !bypass_reg))
    else $error("bypass exit failed");
endmodule

// ===== design/flash_seq_pkg.sv
package flash_seq_pkg;
  localparam int          PRI_SECTORS   = 8;
  localparam int          SEC_SECTORS   = 4;
  localparam int          ADDR_W        = 20;
  localparam int          CMD_ADDR_W    = 12;
  localparam int          SEC_ADDR_W    = 14;
  localparam int          PRI_ADDR_W    = 18;
  localparam int          PRI_SECT_W    = 15;
  localparam int          SEC_SECT_W    = 12;
  localparam logic [11:0] UNLOCK1_ADDR  = 12'hAAA;
  localparam logic [11:0] UNLOCK2_ADDR  = 12'h554;
  localparam logic [11:0] ID_OFFS       = 12'h002;
  localparam logic [11:0] PROT_OFFS     = 12'h004;
  localparam logic [7:0]  CMD_UNLOCK1   = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2   = 8'h55;
  localparam logic [7:0]  CMD_AUTOSEL   = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0]  CMD_ERASE     = 8'h80;
  localparam logic [7:0]  CMD_SECT_ER   = 8'h30;
  localparam logic [7:0]  CMD_CHIP_ER   = 8'h10;
  localparam logic [7:0]  CMD_SUSPEND   = 8'hB0;
  localparam logic [7:0]  CMD_RESET     = 8'hF0;
  localparam logic [7:0]  CMD_BYPASS    = 8'h20;
  localparam logic [7:0]  CMD_BYP_EXIT  = 8'h00;
  localparam logic [15:0] PROT_YES      = 16'h0001;
  localparam logic [15:0] PROT_NO       = 16'h0000;
  localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
  localparam int          CLK_MHZ       = 100;
  localparam int          GAP_US        = 80;
  localparam int          GAP_CYCLES    = GAP_US * CLK_MHZ;
  localparam int          PROG_CYCLES   = 100;
  localparam int          ERASE_CYCLES  = 1000;

  typedef enum logic [3:0] {
    ST_READ   = 4'h0, ST_C1  = 4'h1, ST_C2  = 4'h2, ST_AUTO = 4'h3,
    ST_PDATA  = 4'h4, ST_E3  = 4'h5, ST_E4  = 4'h6, ST_E5   = 4'h7,
    ST_ECOLL  = 4'h8, ST_BUSY = 4'h9, ST_SUSP = 4'hA, ST_BYP = 4'hB,
    ST_BPDATA = 4'hC, ST_BEXIT = 4'hD
  } seq_state_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
  } bus_req_t;
endpackage

// ===== bench/flash_host_model.sv
`timescale 1ns/1ns
module flash_host_model
  import flash_seq_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic [15:0]            rd_data,
  output bus_req_t                    bus_req,
  output logic      [PRI_SECTORS-1:0] pri_sel,
  output logic      [SEC_SECTORS-1:0] sec_sel
);
  // Idle bus with no sector selected
  initial begin
    bus_req = '0;
    pri_sel = '0;
    sec_sel = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bus cycle held until its taking edge; released address and data show the inverse, selects and strobes go low
  task automatic cyc(input logic sec, input logic wr, input logic [19:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr, !wr, a, d};
    pri_sel <= sec ? 8'h00 : 8'h01 << a[17:15];
    sec_sel <= sec ? 4'h1 << a[13:12] : 4'h0;
    @(posedge ref_clk);
    bus_req <= '{1'b0, 1'b0, ~a, ~d};
    pri_sel <= '0;
    sec_sel <= '0;
  endtask

  // Read a word once it has settled
  task automatic rd(input logic sec, input logic [19:0] a, output logic [15:0] q);
    cyc(sec, 1'b0, a, 16'h0000);
    @(posedge ref_clk);
    #1;
    q = rd_data;
  endtask

  // Command byte at a low offset within the page of base
  task automatic cmd(input logic sec, input logic [19:0] base, input logic [11:0] offs, input logic [7:0] b);
    cyc(sec, 1'b1, {base[19:12], offs}, {8'h00, b});
  endtask

  // Two coded cycles
  task automatic unlock(input logic sec, input logic [19:0] base);
    cmd(sec, base, UNLOCK1_ADDR, CMD_UNLOCK1);
    cmd(sec, base, UNLOCK2_ADDR, CMD_UNLOCK2);
  endtask

  // Full word program sequence
  task automatic prog_cmd(input logic sec, input logic [19:0] a, input logic [15:0] d);
    unlock(sec, a);
    cmd(sec, a, UNLOCK1_ADDR, CMD_PROGRAM);
    cyc(sec, 1'b1, a, d);
  endtask

  // Five-write erase preamble
  task automatic erase_pre(input logic sec, input logic [19:0] base);
    unlock(sec, base);
    cmd(sec, base, UNLOCK1_ADDR, CMD_ERASE);
    unlock(sec, base);
  endtask
endmodule

// ===== bench/flash_command_sequencer_test.sv
`timescale 1ns/1ns
module flash_command_sequencer_test;
  import flash_seq_pkg::*;
  localparam int          PT  = 8;
  localparam int          ET  = 40;
  localparam int          GT  = 20;
  localparam logic [15:0] IDC = 16'h00C3;  // Arbitrary identifier value
  logic                   ref_clk;
  logic                   rst_n;
  bus_req_t               bus_req;
  logic [PRI_SECTORS-1:0] pri_sel;
  logic [SEC_SECTORS-1:0] sec_sel;
  logic [PRI_SECTORS-1:0] pri_prot;
  logic [SEC_SECTORS-1:0] sec_prot;
  logic [15:0]            rd_data;
  logic                   rdy;
  logic                   susp;
  int                     fails;
  int                     checks_done;

  flash_command_sequencer #(.PROG_TIME(PT), .ERASE_TIME(ET), .GAP_TIME(GT), .ID_CODE(IDC))
  flash_command_sequencer_i (.REF_CLK(ref_clk), .RST_N(rst_n), .BUS_REQ(bus_req), .PRI_SEL(pri_sel),
    .SEC_SEL(sec_sel), .PRI_PROT(pri_prot), .SEC_PROT(sec_prot), .RD_DATA(rd_data),
    .READY_BUSY_PIN(rdy), .SUSPENDED(susp));

  flash_host_model flash_host_model_i (.ref_clk(ref_clk), .rd_data(rd_data), .bus_req(bus_req),
    .pri_sel(pri_sel), .sec_sel(sec_sel));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Host waits on the ready pin and counts the busy cycles
  task automatic busy_low(output int lows);
    int n;
    lows = 0;
    n = 0;
    #1;
    while (n < 2000 && !(lows > 0 && rdy === 1'b1)) begin
      if (rdy === 1'b0) lows++;
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  task automatic rdchk(input logic sec, input logic [19:0] a, input logic [15:0] exp, input string what);
    logic [15:0] q;
    flash_host_model_i.rd(sec, a, q);
    check(what, q, exp);
  endtask

  task automatic prog(input logic sec, input logic [19:0] a, input logic [15:0] d);
    int lows;
    flash_host_model_i.prog_cmd(sec, a, d);
    busy_low(lows);
    check("program busy cycles", 16'(lows), 16'(PT));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_chip(input logic sec);
    int lows;
    flash_host_model_i.erase_pre(sec, 20'h00000);
    flash_host_model_i.cmd(sec, 20'h00000, UNLOCK1_ADDR, CMD_CHIP_ER);
    busy_low(lows);
    check("chip erase busy cycles", 16'(lows), 16'(ET));
    rdchk(sec, 20'h00ABC, ERASED_WORD, "first sector erased");
    rdchk(sec, sec ? 20'h03FFF : 20'h3FFFF, ERASED_WORD, "last sector");
  endtask

  task automatic t_prog;
    flash_host_model_i.cyc(1'b0, 1'b1, 20'h18010, 16'h1234);
    rdchk(1'b0, 20'h18010, ERASED_WORD, "plain write ignored");
    prog(1'b0, 20'h00123, 16'hA5C3);
    rdchk(1'b0, 20'h00123, 16'hA5C3, "programmed word");
    prog(1'b0, 20'h15456, 16'h3C5A);
    rdchk(1'b0, 20'h15456, 16'h3C5A, "high page bits ignored");
    prog(1'b0, 20'h20789, 16'h0F0F);
    prog(1'b0, 20'h00123, 16'h0FFF);
    rdchk(1'b0, 20'h00123, 16'h05C3, "reprogrammed word");
  endtask

  task automatic t_protect;
    @(posedge ref_clk);
    pri_prot <= 8'h02;
    prog(1'b0, 20'h08040, 16'h0000);
    rdchk(1'b0, 20'h08040, ERASED_WORD, "protected word");
    flash_host_model_i.unlock(1'b0, 20'h00000);
    flash_host_model_i.cmd(1'b0, 20'h00000, UNLOCK1_ADDR, CMD_AUTOSEL);
    rdchk(1'b0, {8'h00, ID_OFFS}, IDC, "identifier");
    rdchk(1'b0, {8'h08, PROT_OFFS}, PROT_YES, "protected");
    rdchk(1'b0, {8'h00, PROT_OFFS}, PROT_NO, "unprotected");
    flash_host_model_i.cmd(1'b0, 20'h00000, 12'h3F2, CMD_RESET);
    rdchk(1'b0, 20'h00123, 16'h05C3, "read after reset cmd");
  endtask

  task automatic t_suspend;
    int n;
    int lows;
    flash_host_model_i.erase_pre(1'b0, 20'h00000);
    flash_host_model_i.cmd(1'b0, 20'h00000, 12'h000, CMD_SECT_ER);
    flash_host_model_i.cmd(1'b0, 20'h10000, 12'h000, CMD_SECT_ER);
    for (n = 0; n < GT + 10 && rdy !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check("erase started", {15'h0, rdy}, 16'h0000);
    flash_host_model_i.cmd(1'b0, 20'h00000, 12'h000, CMD_RESET);
    #1;
    check("busy kept over reset cmd", {15'h0, rdy}, 16'h0000);
    flash_host_model_i.cmd(1'b0, 20'h00000, 12'h5A6, CMD_SUSPEND);
    @(posedge ref_clk);
    #1;
    check("erase paused", {15'h0, susp}, 16'h0001);
    rdchk(1'b0, 20'h20789, 16'h0F0F, "read while paused");
    flash_host_model_i.cmd(1'b0, 20'h00000, 12'h000, CMD_SECT_ER);
    busy_low(lows);
    check("erase resumed", {15'h0, susp}, 16'h0000);
    rdchk(1'b0, 20'h00123, ERASED_WORD, "first erased sector");
    rdchk(1'b0, 20'h15456, ERASED_WORD, "added erased sector");
    rdchk(1'b0, 20'h20789, 16'h0F0F, "sector outside erase");
  endtask

  task automatic t_bypass;
    int lows;
    flash_host_model_i.unlock(1'b0, 20'h28000);
    flash_host_model_i.cmd(1'b0, 20'h28000, UNLOCK1_ADDR, CMD_BYPASS);
    flash_host_model_i.cmd(1'b0, 20'h28000, 12'h776, CMD_PROGRAM);
    flash_host_model_i.cyc(1'b0, 1'b1, 20'h28010, 16'h1234);
    busy_low(lows);
    check("bypass program busy", 16'(lows), 16'(PT));
    flash_host_model_i.cmd(1'b0, 20'h30000, 12'h3C4, CMD_PROGRAM);
    flash_host_model_i.cyc(1'b0, 1'b1, 20'h30020, 16'h4321);
    busy_low(lows);
    flash_host_model_i.cmd(1'b0, 20'h30000, 12'h002, CMD_AUTOSEL);
    flash_host_model_i.cmd(1'b0, 20'h30000, 12'h8E0, CMD_BYP_EXIT);
    rdchk(1'b0, 20'h28010, 16'h1234, "bypass word one");
    rdchk(1'b0, 20'h30020, 16'h4321, "bypass word two");
    flash_host_model_i.cmd(1'b0, 20'h30000, 12'h776, CMD_PROGRAM);
    flash_host_model_i.cyc(1'b0, 1'b1, 20'h30030, 16'h0000);
    rdchk(1'b0, 20'h30030, ERASED_WORD, "short program after exit");
  endtask

  task automatic t_abort;
    flash_host_model_i.unlock(1'b0, 20'h38000);
    flash_host_model_i.cmd(1'b0, 20'h38000, UNLOCK1_ADDR, 8'h77);
    flash_host_model_i.cmd(1'b0, 20'h38000, UNLOCK1_ADDR, CMD_PROGRAM);
    flash_host_model_i.cyc(1'b0, 1'b1, 20'h38100, 16'h0000);
    rdchk(1'b0, 20'h38100, ERASED_WORD, "bad byte abandons");
    flash_host_model_i.unlock(1'b0, 20'h38000);
    repeat (GT + 5) @(posedge ref_clk);
    flash_host_model_i.cmd(1'b0, 20'h38000, UNLOCK1_ADDR, CMD_PROGRAM);
    flash_host_model_i.cyc(1'b0, 1'b1, 20'h38100, 16'h0000);
    rdchk(1'b0, 20'h38100, ERASED_WORD, "long gap abandons");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Watchdog
  initial begin
    #300000;
    fails++;
    end_sim;
  end

  // Main sequence
  initial begin
    fails = 0;
    checks_done = 0;
    rst_n = 1'b0;
    pri_prot = '0;
    sec_prot = '0;
    repeat (19) @(posedge ref_clk);
    #1;
    check("read data in reset", rd_data, 16'h0000);
    check("ready in reset", {15'h0, rdy}, 16'h0001);
    check("pause in reset", {15'h0, susp}, 16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    t_chip(1'b0);
    t_prog;
    t_protect;
    t_suspend;
    t_bypass;
    t_abort;
    t_chip(1'b1);
    prog(1'b1, 20'h01806, 16'h7E81);
    rdchk(1'b1, 20'h01806, 16'h7E81, "secondary word");
    rdchk(1'b0, 20'h01806, ERASED_WORD, "primary apart");
    end_sim;
  end
endmodule
